/* bench/ocd_clk_src.sv */
// Partner model: free-running differential input clock source
`timescale 1ns/1ns
`default_nettype none
module ocd_clk_src #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic inClkP,
  output logic inClkN
);
  int cnt;
  // Each level is held HALF clk cycles; HALF >= 3 so the synchroniser sees every edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      inClkP <= #1 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      inClkP <= #1 ~inClkP;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Complement leg always opposite, never equal, so no held-level case
  assign inClkN = ~inClkP;
endmodule
`default_nettype wire

/* bench/odd_ratio_clock_divider_tb.sv */
// Self-checking testbench for the odd-ratio clock divider
`timescale 1ns/1ns
`default_nettype none
module odd_ratio_clock_divider_tb;
  import ocd_pkg::*;
  localparam int H = 4;
  logic clk, rst_b, inClkP, inClkN, enable, enableDriven, ratioFive, clrN, outClkP, outClkN;
  int failCount = 0;
  int cmpCount = 0;
  ocd_clk_src #(.HALF(H)) ocd_clk_src_i (.clk(clk), .rst_b(rst_b), .inClkP(inClkP),
    .inClkN(inClkN));
  ocd_divider ocd_divider_i (.clk(clk), .rst_b(rst_b), .inClkP(inClkP), .inClkN(inClkN),
    .enable(enable), .enableDriven(enableDriven), .ratioFive(ratioFive),
    .master_clear_n(clrN), .outClkP(outClkP), .outClkN(outClkN));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic printVerdict;
    $display("Counts: %0d compares, %0d mismatches", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chkInt(int got, int exp, string msg);
    cmpCount++;
    if (got != exp) begin
      failCount++;
      $display("Error at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask
  task automatic chkOut(logic p);
    cmpCount++;
    if (outClkP !== p || outClkN !== ~p) begin
      failCount++;
      $display("Error at %0t: output pair %b/%b", $time, outClkP, outClkN);
    end
  endtask
  task automatic drive(logic en, logic drv, logic r, logic clr);
    @(posedge clk);
    #1;
    enable = en;
    enableDriven = drv;
    ratioFive = r;
    clrN = clr;
  endtask
  // Counts sampled cycles until outClkP reaches lvl; bounded, a timeout ends the run
  task automatic waitLevel(logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (outClkP !== lvl && n < 500);
    if (outClkP !== lvl) begin
      failCount++;
      $display("Error at %0t: output stuck", $time);
      printVerdict();
    end
  endtask
  // Stops output, changes the ratio only once stopped, restarts and measures one period
  task automatic testRatio(logic r);
    int n, hi, lo;
    drive(1'b0, 1'b1, ratioFive, 1'b1);
    repeat (100) @(negedge clk);
    drive(1'b0, 1'b1, r, 1'b1);
    drive(1'b1, 1'b1, r, 1'b1);
    waitLevel(1'b1, n);
    chkInt(int'(n >= 2 * H && n <= 4 * H + 4), 1, "resume delay");
    waitLevel(1'b0, hi);
    chkOut(1'b0);
    waitLevel(1'b1, lo);
    chkInt(hi, (r ? 5 : 3) * H, "high width");
    chkInt(lo, (r ? 5 : 3) * H, "low width");
    $display("testRatio %0d done", r);
  endtask
  task automatic testDisable;
    int n, hi, extra;
    extra = 0;
    waitLevel(1'b1, n);
    drive(1'b0, 1'b1, 1'b1, 1'b1);
    waitLevel(1'b0, hi);
    chkInt(hi + 1, 5 * H, "last pulse width");
    repeat (60) begin
      @(negedge clk);
      if (outClkP !== 1'b0) extra++;
    end
    chkInt(extra, 0, "pulses while disabled");
    chkOut(1'b0);
    $display("testDisable done");
  endtask
  task automatic testOpen;
    int n, hi;
    drive(1'b0, 1'b1, 1'b0, 1'b1);
    drive(1'b0, 1'b0, 1'b0, 1'b1);
    waitLevel(1'b1, n);
    waitLevel(1'b0, hi);
    chkInt(hi, 3 * H, "open enable pulse");
    $display("testOpen done");
  endtask
  // Disables just after an output fall: one more full pulse must still go out
  task automatic testDrainLow;
    int n, hi, extra;
    extra = 0;
    drive(1'b0, 1'b1, 1'b0, 1'b1);
    waitLevel(1'b1, n);
    waitLevel(1'b0, hi);
    chkInt(hi, 3 * H, "pulse after late disable");
    repeat (40) begin
      @(negedge clk);
      if (outClkP !== 1'b0) extra++;
    end
    chkInt(extra, 0, "pulses after drain");
    $display("testDrainLow done");
  endtask
  // Clears in mid pulse, then checks the count restarts from its initial state
  task automatic testClear;
    int n, hi, extra;
    extra = 0;
    drive(1'b1, 1'b1, 1'b0, 1'b1);
    waitLevel(1'b1, n);
    drive(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    repeat (50) begin
      @(negedge clk);
      if (outClkP !== 1'b0) extra++;
    end
    chkInt(extra, 0, "pulses under clear");
    chkOut(1'b0);
    drive(1'b1, 1'b1, 1'b0, 1'b1);
    waitLevel(1'b1, n);
    waitLevel(1'b0, hi);
    chkInt(hi, 3 * H, "pulse after clear");
    $display("testClear done");
  endtask
  initial begin
    rst_b = 0;
    enable = 0;
    enableDriven = 1;
    ratioFive = 0;
    clrN = 1;
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1;
    testRatio(1'b0);
    testRatio(1'b1);
    testDisable();
    testOpen();
    testDrainLow();
    testClear();
    printVerdict();
  end
endmodule
`default_nettype wire

/* inc/ocd_pkg.sv */
// Shared constants and types for the odd-ratio clock divider
package ocd_pkg;
  localparam int OCD_PH_W = 4;
  localparam logic [OCD_PH_W-1:0] OCD_DIV_LO = 4'h3;
  localparam logic [OCD_PH_W-1:0] OCD_DIV_HI = 4'h5;
  localparam logic [OCD_PH_W-1:0] OCD_PH_ZERO = 4'h0;
  localparam int OCD_SYNC_W = 6;
  localparam logic [OCD_SYNC_W-1:0] OCD_SYNC_RST = 6'h00;
  typedef enum logic [2:0] {
    OCD_OFF,
    OCD_WAIT_FALL,
    OCD_RUN,
    OCD_DRAIN
  } ocd_state_t;
endpackage

/* rtl/ocd_divider.sv */
// Odd-ratio clock divider with glitch-free enable gating
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [RULE_01] Divided output passes while enable is high, suppressed while low.
// [RULE_02] An undriven enable pin counts as high, so output runs by default.
// [RULE_03] After enable rises, output resumes after one input rise then one fall.
// [RULE_04] After enable falls, output stops after input rise then output fall.
// [RULE_05] Disabling never shortens a high pulse; it always completes full width.
// [RULE_06] Divider advances on both rising and falling input clock edges.
// [RULE_07] Divide by three: output falls at falling edge of second input cycle.
// [RULE_08] Divide by five: output falls at falling edge of third input cycle.
// [RULE_09] Ratio select is static; taken only while disabled or cleared.
// [RULE_10] Disabled: true output low, complement high; master clear resets count.
module ocd_divider
  import ocd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inClkP,
  input wire logic inClkN,
  input wire logic enable,
  input wire logic enableDriven,
  input wire logic ratioFive,
  input wire logic master_clear_n,
  output logic outClkP,
  output logic outClkN
);
  logic [OCD_SYNC_W-1:0] pinSync;
  logic sP, sN, sEn, sEnDrv, sRatio, sClr_n;
  logic level_q, level_d, prev_q;
  logic rise, fall, edgeAny, enEff;
  ocd_state_t state_q, state_d;
  logic [OCD_PH_W-1:0] phase_q, phase_d, phaseAdv, nHalf, lastPh;
  logic ratio_q, ratio_d;
  logic outP_q, outP_d, outN_q;

  // Every pin costs two clk cycles of synchroniser latency; input half-cycles must span three clk
  ocd_sync #(.W(OCD_SYNC_W)) ocd_sync_i (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({inClkP, inClkN, enable, enableDriven, ratioFive, master_clear_n}),
    .pinSync(pinSync)
  );

  assign {sP, sN, sEn, sEnDrv, sRatio, sClr_n} = pinSync;
  // Pull-up behaviour: no driver on the pin means enabled
  assign enEff = sEn | ~sEnDrv; // RULE_02
  // Equal legs of the pair carry no information, so keep the last level
  assign level_d = (sP != sN) ? sP : level_q;
  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;
  assign edgeAny = rise | fall; // RULE_06
  assign nHalf = ratio_q ? OCD_DIV_HI : OCD_DIV_LO; // RULE_07 RULE_08
  assign lastPh = OCD_PH_W'((nHalf << 1) - 4'h1);
  assign phaseAdv = (phase_q == lastPh) ? OCD_PH_ZERO : OCD_PH_W'(phase_q + 4'h1); // RULE_06

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    ratio_d = ratio_q;
    if (!sClr_n) begin
      state_d = OCD_OFF; // RULE_10
      phase_d = OCD_PH_ZERO; // RULE_10
      ratio_d = sRatio; // RULE_09
    end else begin
      unique case (state_q)
        OCD_OFF: begin
          ratio_d = sRatio; // RULE_09
          if (enEff && rise) begin
            state_d = OCD_WAIT_FALL; // RULE_03
          end
        end
        OCD_WAIT_FALL: begin
          if (!enEff) begin
            state_d = OCD_OFF;
          end else if (fall) begin
            state_d = OCD_RUN; // RULE_03
            phase_d = lastPh;
          end
        end
        OCD_RUN: begin
          if (edgeAny) begin
            phase_d = phaseAdv;
          end
          if (!enEff && rise) begin
            state_d = OCD_DRAIN; // RULE_04
          end
        end
        OCD_DRAIN: begin
          // Keep counting until the next output fall ends a full-width pulse, then stop
          if (edgeAny) begin
            phase_d = phaseAdv;
            if (fall && phaseAdv == nHalf) begin
              state_d = OCD_OFF; // RULE_05
            end
          end
        end
        default: begin
          state_d = OCD_OFF;
        end
      endcase
    end
    outP_d = (state_d == OCD_RUN || state_d == OCD_DRAIN) && (phase_d < nHalf); // RULE_01
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
      prev_q <= 1'b0;
      state_q <= OCD_OFF;
      phase_q <= OCD_PH_ZERO;
      ratio_q <= 1'b0;
      outP_q <= 1'b0;
      outN_q <= 1'b1;
    end else begin
      level_q <= level_d;
      prev_q <= level_q;
      state_q <= state_d;
      phase_q <= phase_d;
      ratio_q <= ratio_d;
      outP_q <= outP_d;
      outN_q <= ~outP_d; // RULE_10
    end
  end

  assign outClkP = outP_q;
  assign outClkN = outN_q;

  // Half-cycles seen while the output is high, for pulse width checks
  logic [OCD_PH_W-1:0] hiCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hiCnt_q <= OCD_PH_ZERO;
    end else if (!outP_q) begin
      hiCnt_q <= OCD_PH_ZERO;
    end else if (edgeAny) begin
      hiCnt_q <= OCD_PH_W'(hiCnt_q + 4'h1);
    end
  end

  // Half-cycles seen while a running output is low, for low time checks
  logic [OCD_PH_W-1:0] loCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loCnt_q <= OCD_PH_ZERO;
    end else if (outP_q || !(state_q == OCD_RUN || state_q == OCD_DRAIN)) begin
      loCnt_q <= OCD_PH_ZERO;
    end else if (edgeAny) begin
      loCnt_q <= OCD_PH_W'(loCnt_q + 4'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rise_seen;
    rise && state_q == OCD_OFF && enEff && sClr_n;
  endsequence
  sequence s_run_entered;
    state_q == OCD_RUN && outClkP == 1'b0;
  endsequence

  a_off_levels: assert property (state_q == OCD_OFF |-> !outClkP && outClkN) // RULE_10
    else $error("Outputs not parked while disabled");
  a_pair_compl: assert property (outClkP != outClkN) // RULE_01
    else $error("Output pair not complementary");
  sequence s_wait_idle;
    state_q == OCD_WAIT_FALL && !fall && enEff && sClr_n;
  endsequence
  sequence s_drain_low;
    state_q == OCD_DRAIN && !outClkP && sClr_n;
  endsequence

  a_undriven_en: assert property // RULE_02
    (!sEnDrv && sClr_n && state_q == OCD_OFF && rise |=> state_q == OCD_WAIT_FALL)
    else $error("Undriven enable did not start the divider");
  a_resume_order: assert property (s_rise_seen |=> state_q == OCD_WAIT_FALL) // RULE_03
    else $error("Enable did not wait for input rising edge");
  a_resume_fall: assert property // RULE_03
    (state_q == OCD_WAIT_FALL && fall && enEff && sClr_n |=> s_run_entered)
    else $error("Output did not resume on input falling edge");
  a_wait_hold: assert property // RULE_03
    (s_wait_idle |=> state_q == OCD_WAIT_FALL && !outClkP)
    else $error("Output resumed before input falling edge");
  a_stop_cause: assert property // RULE_04
    ($changed(state_q) && state_q == OCD_OFF && $past(sClr_n) && $past(state_q) == OCD_DRAIN
      |-> $past(fall) && $fell(outClkP))
    else $error("Disable did not end on output falling edge");
  a_drain_entry: assert property // RULE_04
    (state_q == OCD_RUN && !enEff && rise && sClr_n |=> state_q == OCD_DRAIN)
    else $error("Disable not taken on input rising edge");
  a_full_width: assert property // RULE_05
    ($fell(outClkP) && $past(sClr_n) |-> $past(hiCnt_q) == nHalf - 4'h1)
    else $error("Output high pulse truncated");
  a_drain_low: assert property (s_drain_low |=> state_q == OCD_DRAIN) // RULE_05
    else $error("Stopped without finishing a pulse");
  a_hold_noedge: assert property // RULE_06
    (!edgeAny && sClr_n && state_q != OCD_WAIT_FALL |=> $stable(phase_q))
    else $error("Divider moved without an input edge");
  a_rise_phase: assert property // RULE_06
    ($rose(outClkP) |-> $past(rise) && phase_q == OCD_PH_ZERO)
    else $error("Output rose off an input rising edge");
  // The first pulse after a restart follows a single low half-cycle, so it is skipped
  a_low_width: assert property // RULE_06
    ($rose(outClkP) && $past(sClr_n) && $past(loCnt_q) != OCD_PH_ZERO
      |-> $past(loCnt_q) == nHalf - 4'h1)
    else $error("Output low time wrong");
  a_div3_fall: assert property // RULE_07
    ($fell(outClkP) && !ratio_q && $past(sClr_n) |-> $past(fall) && phase_q == OCD_DIV_LO)
    else $error("Divide by three fall misplaced");
  a_div5_fall: assert property // RULE_08
    ($fell(outClkP) && ratio_q && $past(sClr_n) |-> $past(fall) && phase_q == OCD_DIV_HI)
    else $error("Divide by five fall misplaced");
  a_ratio_static: assert property // RULE_09
    (state_q != OCD_OFF && sClr_n |=> $stable(ratio_q))
    else $error("Ratio changed while running");
  a_ratio_taken: assert property // RULE_09
    ((state_q == OCD_OFF || !sClr_n) |=> ratio_q == $past(sRatio))
    else $error("Ratio not taken while stopped");
  a_off_hold: assert property // RULE_01
    (state_q == OCD_OFF && !enEff && sClr_n |=> state_q == OCD_OFF && !outClkP)
    else $error("Output started while disabled");
  a_clear_count: assert property (!sClr_n |=> phase_q == OCD_PH_ZERO && state_q == OCD_OFF) // RULE_10
    else $error("Master clear did not reset divider");
endmodule
`default_nettype wire

/* rtl/ocd_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module ocd_sync
  import ocd_pkg::*;
#(
  parameter int W = OCD_SYNC_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pinIn[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pinSync = sync_q;
endmodule
`default_nettype wire
